// file: rtl/sadc_pkg.sv
`default_nettype none
package sadc_pkg;

    // Converter geometry.
    localparam int unsigned RES_BITS  = 12;
    localparam int unsigned CTRL_BITS = 8;
    localparam int unsigned TRACK_AT  = 5;

    localparam logic [3:0]  MSB_IDX   = 4'hb;
    localparam logic [11:0] MSB_TRIAL = 12'h800;
    localparam logic [11:0] ZERO_CODE = 12'h000;
    localparam logic [3:0]  CNT_ONE   = 4'h1;
    localparam logic [3:0]  CNT_CTRL  = 4'h8;
    localparam logic [3:0]  CNT_TRACK = 4'h5;
    localparam logic [4:0]  OUT_RES   = 5'h0c;
    localparam logic [4:0]  OUT_SAT   = 5'h1f;

    // Control byte fields below the start bit.
    localparam int unsigned SEL_MSB = 6;
    localparam int unsigned SEL_LSB = 4;
    localparam int unsigned UNI_BIT = 3;
    localparam int unsigned SGL_BIT = 2;
    localparam int unsigned PD_MSB  = 1;
    localparam int unsigned PD_LSB  = 0;
    localparam logic [6:0]  CTRL_RST = 7'h00;

    // Power-down field codes.
    localparam logic [1:0] PD_EXT_CLK = 2'h3;
    localparam logic [1:0] PD_INT_CLK = 2'h2;

    // Three-level power-down pin, as reported by the pad.
    localparam logic [1:0] PIN_LOW  = 2'h0;
    localparam logic [1:0] PIN_MID  = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h3;

    // Clock rates and the divider counts derived from them.
    localparam int unsigned CORE_CLK_HZ = 50_000_000;
    localparam int unsigned INT_FAST_HZ = 1_800_000;
    localparam int unsigned INT_SLOW_HZ = 225_000;
    localparam logic [7:0]  FAST_DIV    = 8'(CORE_CLK_HZ / INT_FAST_HZ);
    localparam logic [7:0]  SLOW_DIV    = 8'(CORE_CLK_HZ / INT_SLOW_HZ);
    localparam logic [7:0]  DIV_ONE     = 8'h01;

    typedef enum logic {
        SADC_IDLE,
        SADC_CONV
    } sadc_state_type;

    // One successive-approximation decision on bit idx.
    function automatic logic [11:0] sadc_sar_step(
        input logic [11:0] trial,
        input logic [3:0]  idx,
        input logic        keep
    );
        logic [11:0] t;
        t = trial;
        t[idx] = keep;
        if (idx != 4'h0) begin
            t[idx - CNT_ONE] = 1'b1;
        end
        return t;
    endfunction

endpackage
`default_nettype wire

// file: rtl/sadc_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_sync3
    import sadc_pkg::*;
#(
    parameter int unsigned W = 1
) (
    // Clock, reset and enable.
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // Asynchronous input and its settled copy.
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;

    // A change is taken only once stages two and three agree.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            out_reg <= '0;
        end else if (ce_i) begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    out_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    assign sync_o = out_reg;

endmodule
`default_nettype wire

// file: rtl/sadc_top.sv
// Contract
// - Power-down pin low shuts the converter down.
// - Pin floating: internal clock 1.8MHz.
// - Pin high: internal clock 225kHz.
// - Result bits change on falling serial clock.
// - Data output driven only while select low.
// - Command input sampled on rising serial clock.
// - Command bits ignored while select high.
// - Internal mode: strobe low during conversion.
// - External mode: one-period strobe before MSB.
// - External mode: strobe driven only while selected.
// - Twelve bits, one decision per clock.
// - Conversion time is twelve clock periods.
// - Leading zeros dropped; first one starts byte.
// - Track after bit five, hold after eight.
`timescale 1ns/100ps
`default_nettype none
module sadc_top
    import sadc_pkg::*;
(
    // Core clock, reset and enable.
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // Serial link.
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        din_i,
    output logic             dout_o,
    output logic             dout_oe_o,
    output logic             conversion_strobe_o,
    output logic             conversion_strobe_oe_o,
    // Three-level power-down pin as decoded by the pad.
    input  wire logic [1:0]  power_down_level_pin_i,
    // Analog front end.
    input  wire logic        comp_i,
    output logic      [11:0] dac_code_o,
    output logic      [2:0]  channel_sel_o,
    output logic             unipolar_o,
    output logic             single_ended_o,
    output logic             soft_power_down_o,
    output logic             track_o,
    output logic             hold_o,
    output logic             shutdown_o
);

    // Core reset release.
    logic rst_a_reg;
    logic rst_b_reg;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_a_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_b_reg <= rst_a_reg;
        end
    end

    assign rst_n = rst_b_reg;

    // Link domain. Frame state is cleared by chip select itself, because
    // the serial clock stands still between frames.
    wire link_rst_n = rst_n & ~cs_n_i;

    logic        got_start_reg;
    logic [3:0]  rx_cnt_reg;
    logic [6:0]  ctrl_reg;
    logic [6:0]  cfg_reg;
    logic        track_reg;
    logic        hold_reg;
    logic [4:0]  out_cnt_reg;
    logic        dout_reg;
    logic        ext_strb_reg;
    logic [11:0] ext_trial_reg;
    logic [3:0]  ext_idx_reg;
    logic        req_tgl_reg;

    wire ctrl_done = (rx_cnt_reg == CNT_CTRL);
    wire ctrl_ext  = (ctrl_reg[PD_MSB:PD_LSB] == PD_EXT_CLK);
    wire cfg_ext   = (cfg_reg[PD_MSB:PD_LSB] == PD_EXT_CLK);
    wire hold_now  = ctrl_done && !hold_reg;
    wire in_result = hold_reg && (out_cnt_reg < OUT_RES);
    wire [3:0] rd_idx = MSB_IDX - out_cnt_reg[3:0];

    logic [11:0] int_result_reg;

    // Command shift register on the rising edge.
    always_ff @(posedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            got_start_reg <= 1'b0;
            rx_cnt_reg    <= '0;
            ctrl_reg      <= CTRL_RST;
        end else if (!got_start_reg) begin
            if (din_i) begin
                got_start_reg <= 1'b1;
                rx_cnt_reg    <= CNT_ONE;
            end
        end else if (rx_cnt_reg < CNT_CTRL) begin
            ctrl_reg   <= {ctrl_reg[5:0], din_i};
            rx_cnt_reg <= rx_cnt_reg + CNT_ONE;
        end
    end

    // Track, hold, strobe and result output on the falling edge.
    always_ff @(negedge sclk_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            track_reg     <= 1'b0;
            hold_reg      <= 1'b0;
            out_cnt_reg   <= '0;
            dout_reg      <= 1'b0;
            ext_strb_reg  <= 1'b0;
            ext_trial_reg <= ZERO_CODE;
            ext_idx_reg   <= MSB_IDX;
        end else if (hold_now) begin
            track_reg     <= 1'b0;
            hold_reg      <= 1'b1;
            out_cnt_reg   <= '0;
            dout_reg      <= 1'b0;
            ext_strb_reg  <= ctrl_ext;
            ext_trial_reg <= ctrl_ext ? MSB_TRIAL : ZERO_CODE;
            ext_idx_reg   <= MSB_IDX;
        end else if (hold_reg) begin
            ext_strb_reg <= 1'b0;
            if (out_cnt_reg != OUT_SAT) begin
                out_cnt_reg <= out_cnt_reg + 5'h01;
            end
            if (in_result) begin
                dout_reg <= cfg_ext ? comp_i : int_result_reg[rd_idx];
                if (cfg_ext) begin
                    ext_trial_reg <= sadc_sar_step(ext_trial_reg,
                                                   ext_idx_reg, comp_i);
                    ext_idx_reg   <= ext_idx_reg - CNT_ONE;
                end
            end else begin
                dout_reg <= 1'b0;
            end
        end else if (rx_cnt_reg == CNT_TRACK) begin
            track_reg <= 1'b1;
        end
    end

    // Configuration lives across frames; only core reset clears it.
    always_ff @(negedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg     <= CTRL_RST;
            req_tgl_reg <= 1'b0;
        end else if (hold_now && !cs_n_i) begin
            cfg_reg <= ctrl_reg;
            if (!ctrl_ext) begin
                req_tgl_reg <= ~req_tgl_reg;
            end
        end
    end

    // Core domain: pin level, comparator and conversion request.
    logic [2:0] pin_sync;
    logic       req_sync;
    logic       req_seen_reg;

    sadc_sync3 #(
        .W (3)
    ) u_pin_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .async_i ({~power_down_level_pin_i, comp_i}),
        .sync_o  (pin_sync)
    );

    sadc_sync3 #(
        .W (1)
    ) u_req_sync (
        .clk_i   (core_clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .async_i (req_tgl_reg),
        .sync_o  (req_sync)
    );

    // The pin travels inverted so that the cleared synchroniser reads as
    // pin high, and no false shutdown follows the release of reset.
    wire [1:0] pin_level = ~pin_sync[2:1];
    wire       comp_sync = pin_sync[0];
    wire       shut_w    = (pin_level == PIN_LOW);
    wire [7:0] conv_div  = (pin_level == PIN_HIGH) ? SLOW_DIV
                                                   : FAST_DIV;
    wire       conv_req  = (req_sync != req_seen_reg);

    sadc_state_type state_reg;
    sadc_state_type state_next;
    logic [7:0]     div_reg;
    logic [3:0]     int_idx_reg;
    logic [11:0]    int_trial_reg;
    logic           shut_reg;

    wire tick     = (div_reg == conv_div - DIV_ONE);
    wire last_bit = tick && (int_idx_reg == 4'h0);
    wire int_busy = (state_reg == SADC_CONV);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SADC_IDLE: begin
                if (conv_req && !shut_w) begin
                    state_next = SADC_CONV;
                end
            end
            SADC_CONV: begin
                if (shut_w || last_bit) begin
                    state_next = SADC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= SADC_IDLE;
            req_seen_reg <= 1'b0;
            shut_reg <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
            req_seen_reg <= req_sync;
            shut_reg <= shut_w;
        end
    end

    // Internal-clock successive approximation, one decision per tick.
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_reg        <= '0;
            int_idx_reg    <= MSB_IDX;
            int_trial_reg  <= ZERO_CODE;
            int_result_reg <= ZERO_CODE;
        end else if (ce_i) begin
            if (state_reg == SADC_IDLE) begin
                div_reg       <= '0;
                int_idx_reg   <= MSB_IDX;
                int_trial_reg <= MSB_TRIAL;
            end else if (tick) begin
                div_reg       <= '0;
                int_idx_reg   <= int_idx_reg - CNT_ONE;
                int_trial_reg <= sadc_sar_step(int_trial_reg, int_idx_reg,
                                               comp_sync);
                if (last_bit) begin
                    int_result_reg <= sadc_sar_step(int_trial_reg,
                                                    int_idx_reg, comp_sync);
                end
            end else begin
                div_reg <= div_reg + DIV_ONE;
            end
        end
    end

    // Pins. The internal result is read by the link side only after the
    // strobe has risen, so it is static while the host clocks it out.
    assign dout_o                 = dout_reg;
    assign dout_oe_o              = ~cs_n_i;
    assign conversion_strobe_o    = cfg_ext ? ext_strb_reg : ~int_busy;
    assign conversion_strobe_oe_o = cfg_ext ? ~cs_n_i : 1'b1;
    assign dac_code_o             = cfg_ext ? ext_trial_reg : int_trial_reg;
    assign channel_sel_o          = cfg_reg[SEL_MSB:SEL_LSB];
    assign unipolar_o             = cfg_reg[UNI_BIT];
    assign single_ended_o         = cfg_reg[SGL_BIT];
    assign soft_power_down_o      = ~cfg_reg[PD_MSB];
    assign track_o                = track_reg;
    assign hold_o                 = hold_reg;
    assign shutdown_o             = shut_reg;

    // Checks on the link side.
    chk_strobe_one_period: assert property (
        @(negedge sclk_i) disable iff (!link_rst_n)
        $rose(ext_strb_reg) |=> !ext_strb_reg ##0 out_cnt_reg == 5'h01)
        else $error("strobe pulse not one period before MSB");

    chk_hold_after_eight: assert property (
        @(negedge sclk_i) disable iff (!link_rst_n)
        $rose(hold_reg) |-> $past(rx_cnt_reg) == CNT_CTRL && !track_reg)
        else $error("hold not after eighth control bit");

    chk_track_after_five: assert property (
        @(negedge sclk_i) disable iff (!link_rst_n)
        $rose(track_reg) |-> $past(rx_cnt_reg) == CNT_TRACK)
        else $error("track not after fifth control bit");

    chk_dout_padding: assert property (
        @(negedge sclk_i) disable iff (!link_rst_n)
        hold_reg && out_cnt_reg >= OUT_RES |=> !dout_reg)
        else $error("padding bit not zero");

    chk_start_discard: assert property (
        @(posedge sclk_i) disable iff (!link_rst_n)
        !got_start_reg && !din_i |=> !got_start_reg && rx_cnt_reg == 4'h0)
        else $error("leading zero was not discarded");

    // Checks on the core side.
    logic [11:0] conv_cyc_reg;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            conv_cyc_reg <= '0;
        end else if (ce_i) begin
            conv_cyc_reg <= int_busy ? conv_cyc_reg + 12'h001 : 12'h000;
        end
    end

    chk_conv_length: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        $fell(int_busy) && !$past(shut_w)
        |-> conv_cyc_reg == 12'(RES_BITS * conv_div))
        else $error("conversion length not twelve clock periods");

    chk_shutdown_idle: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        ce_i && shut_w |=> !int_busy)
        else $error("conversion running in shutdown");

    chk_strobe_busy: assert property (
        @(posedge core_clk_i) disable iff (!rst_n)
        !cfg_ext && $fell(conversion_strobe_o)
        |-> $past(conv_req) && int_trial_reg == MSB_TRIAL)
        else $error("strobe fell without a conversion start");

endmodule
`default_nettype wire

// file: dv/sadc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_host_model
    import sadc_pkg::*;
(
    // Serial link toward the converter.
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      din_o,
    input  wire logic dout_i,
    input  wire logic strobe_i,
    input  wire logic track_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end

    // Equal 24 ns halves keep the duty cycle at 50 percent.
    task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx,
                              output logic [7:0] sb, output logic [7:0] tk);
        for (int i = 7; i >= 0; i--) begin
            din_o = tx[i];
            #24 sclk_o = 1'b1;
            rx[i] = dout_i;
            sb[i] = strobe_i;
            tk[i] = track_i;
            #24 sclk_o = 1'b0;
        end
    endtask

    // A nonzero lead first clocks a byte of ones with select high.
    task automatic frame(input logic [7:0] ctrl, input logic [1:0] lead,
                         output logic [15:0] res, output logic [15:0] sb,
                         output logic [7:0] tk, output logic err);
        logic [7:0] rx;
        logic [7:0] sx;
        logic [7:0] tx;
        int         n;
        err = 1'b0;
        n = 0;
        if (lead != 2'h0) begin
            shift_byte(8'hff, rx, sx, tx);
        end
        cs_n_o = 1'b0;
        #48;
        for (int k = 0; k < int'(lead); k++) begin
            shift_byte(8'h00, rx, sx, tx);
        end
        shift_byte(ctrl, rx, sx, tk);
        if (ctrl[1:0] != PD_EXT_CLK) begin
            #1;
            while (strobe_i === 1'b1 && n < 200) begin
                #20;
                n++;
            end
            err = (n >= 200);
            while (strobe_i !== 1'b1 && n < 4000) begin
                #20;
                n++;
            end
            err = err | (strobe_i !== 1'b1);
        end
        shift_byte(8'h00, res[15:8], sb[15:8], tx);
        shift_byte(8'h00, res[7:0], sb[7:0], tx);
        cs_n_o = 1'b1;
        // A released data line must not look like the last bit sent.
        din_o = ~din_o;
        #48;
    endtask
endmodule
`default_nettype wire

// file: dv/test_serial_adc_conversion_interface.sv
`timescale 1ns/100ps
`default_nettype none
module test_serial_adc_conversion_interface
    import sadc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [1:0]  pin;
        logic [11:0] tgt;
        logic [1:0]  lead;
    } sadc_row_type;

    localparam sadc_row_type ROWS [7] = '{
        '{8'hff, PIN_HIGH, 12'hfff, 2'h0}, '{8'h8f, PIN_MID, 12'h000, 2'h0},
        '{8'hb3, PIN_HIGH, 12'ha5c, 2'h1}, '{8'hce, PIN_MID, 12'h123, 2'h0},
        '{8'hd6, PIN_HIGH, 12'h800, 2'h0}, '{8'h99, PIN_MID, 12'h7ff, 2'h2},
        '{8'hf4, PIN_HIGH, 12'h001, 2'h0}};

    logic        core_clk_i = 1'b0;
    logic        rst_n_i;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        stb;
    logic        stb_oe;
    logic [1:0]  pin;
    logic        comp;
    logic [11:0] dac;
    logic [2:0]  sel;
    logic        uni;
    logic        sgl;
    logic        spd;
    logic        trk;
    logic        hld;
    logic        sd;
    logic [11:0] target;
    int          fail_count;
    int          comparisons;
    int          busy_cnt;

    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    // Released lines show the inverse of the held value, never a stale bit.
    wire dout_line = dout_oe ? dout : ~dout;
    wire stb_line  = stb_oe ? stb : ~stb;
    // Ideal comparator: keep the trial bit while the input is not below it.
    assign comp = (target >= dac);

    // Sampled on the falling edge, away from the edge that moves the strobe.
    always @(negedge core_clk_i) begin
        if (hld && !stb) begin
            busy_cnt++;
        end
    end

    sadc_top u_dut (
        .core_clk_i             (core_clk_i),
        .rst_n_i                (rst_n_i),
        .ce_i                   (1'b1),
        .sclk_i                 (sclk),
        .cs_n_i                 (cs_n),
        .din_i                  (din),
        .dout_o                 (dout),
        .dout_oe_o              (dout_oe),
        .conversion_strobe_o    (stb),
        .conversion_strobe_oe_o (stb_oe),
        .power_down_level_pin_i (pin),
        .comp_i                 (comp),
        .dac_code_o             (dac),
        .channel_sel_o          (sel),
        .unipolar_o             (uni),
        .single_ended_o         (sgl),
        .soft_power_down_o      (spd),
        .track_o                (trk),
        .hold_o                 (hld),
        .shutdown_o             (sd)
    );

    sadc_host_model u_host (
        .sclk_o   (sclk),
        .cs_n_o   (cs_n),
        .din_o    (din),
        .dout_i   (dout_line),
        .strobe_i (stb_line),
        .track_i  (trk)
    );

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic run_row(input sadc_row_type r);
        logic [15:0] res;
        logic [15:0] sb;
        logic [7:0]  tk;
        logic        err;
        logic        ext;
        logic [31:0] div;
        @(negedge core_clk_i);
        pin = r.pin;
        target = r.tgt;
        repeat (10) @(negedge core_clk_i);
        busy_cnt = 0;
        u_host.frame(r.ctrl, r.lead, res, sb, tk, err);
        ext = (r.ctrl[1:0] == PD_EXT_CLK);
        div = (r.pin == PIN_HIGH) ? 32'(SLOW_DIV) : 32'(FAST_DIV);
        check("timeout", 32'(err), 32'h0);
        check("result", 32'(res), {17'h0, r.tgt, 3'h0});
        check("track", 32'(tk), 32'h07);
        if (ext) begin
            check("strobe", 32'(sb), 32'h8000);
        end else begin
            check("busy", 32'(busy_cnt), 32'(RES_BITS) * div);
        end
        check("cfg", {26'h0, sel, uni, sgl, ~spd}, {26'h0, r.ctrl[6:1]});
        check("dout_oe", 32'(dout_oe), 32'h0);
        check("strobe_oe", 32'(stb_oe), 32'(!ext));
    endtask

    initial begin
        rst_n_i = 1'b0;
        pin = PIN_MID;
        target = 12'h000;
        fail_count = 0;
        comparisons = 0;
        busy_cnt = 0;
        repeat (5) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        repeat (5) @(negedge core_clk_i);
        foreach (ROWS[i]) begin
            run_row(ROWS[i]);
        end
        pin = PIN_LOW;
        repeat (8) @(negedge core_clk_i);
        check("shutdown", 32'(sd), 32'h1);
        pin = PIN_HIGH;
        repeat (8) @(negedge core_clk_i);
        check("shutdown", 32'(sd), 32'h0);
        // A second reset in mid-run must bring the outputs back to idle.
        rst_n_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        check("reset", {16'h0, dout, stb, stb_oe, dac, sd}, 32'h6000);
        rst_n_i = 1'b1;
        repeat (4) @(negedge core_clk_i);
        check("shutdown", 32'(sd), 32'h0);
        @(negedge core_clk_i);
        run_row(ROWS[3]);
        final_report();
    end
endmodule
`default_nettype wire
